// [pkg/rtch_pkg.sv]
`default_nettype none
package rtch_pkg;
  // register indices on the 4-bit bus
  localparam logic [3:0] RTCH_IDX_SEC1  = 4'h0;
  localparam logic [3:0] RTCH_IDX_SEC10 = 4'h1;
  localparam logic [3:0] RTCH_IDX_MIN1  = 4'h2;
  localparam logic [3:0] RTCH_IDX_MIN10 = 4'h3;
  localparam logic [3:0] RTCH_IDX_HR1   = 4'h4;
  localparam logic [3:0] RTCH_IDX_HR10  = 4'h5;
  localparam logic [3:0] RTCH_IDX_DAY1  = 4'h6;
  localparam logic [3:0] RTCH_IDX_DAY10 = 4'h7;
  localparam logic [3:0] RTCH_IDX_MON1  = 4'h8;
  localparam logic [3:0] RTCH_IDX_MON10 = 4'h9;
  localparam logic [3:0] RTCH_IDX_YR1   = 4'ha;
  localparam logic [3:0] RTCH_IDX_YR10  = 4'hb;
  localparam logic [3:0] RTCH_IDX_WDAY  = 4'hc;
  localparam logic [3:0] RTCH_IDX_CTLD  = 4'hd;
  // control register d bit positions
  localparam int RTCH_BIT_HOLD = 0;
  localparam int RTCH_BIT_BUSY = 1;
  localparam int RTCH_BIT_IRQ  = 2;
  localparam int RTCH_BIT_ADJ  = 3;
  // writable-bit masks per register, unused bits read 0
  localparam logic [3:0] RTCH_MASK_3BIT = 4'h7;
  localparam logic [3:0] RTCH_MASK_2BIT = 4'h3;
  localparam logic [3:0] RTCH_MASK_1BIT = 4'h1;
  localparam logic [3:0] RTCH_MASK_4BIT = 4'hf;
  // counter limits (bcd digits)
  localparam logic [3:0] RTCH_MAX_DIGIT = 4'h9;
  localparam logic [3:0] RTCH_MAX_TENS6 = 4'h5;
  localparam logic [3:0] RTCH_MAX_WDAY  = 4'h6;
  localparam logic [3:0] RTCH_RST_DIGIT = 4'h0;
  // timing
  localparam int RTCH_CLK_HZ      = 50_000_000;
  localparam int RTCH_TICK_HZ     = 1;
  localparam int RTCH_TICK_CYCLES = RTCH_CLK_HZ / RTCH_TICK_HZ;
  localparam int RTCH_BUSY_CYCLES = 4;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [3:0] wdata;
  } rtch_req_t;
endpackage
`default_nettype wire

// [src/rtch_core.sv]
`timescale 1ns/1ps
`default_nettype none
module rtch_core
  import rtch_pkg::*;
#(
  parameter int TICK_CYCLES = RTCH_TICK_CYCLES
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire rtch_req_t  req,
  input  wire logic       periodic_evt,
  output var  logic [3:0] rdata_q,
  output var  logic       busy_q,
  output var  logic       irq_flag_q,
  output var  logic       periodic_output_pin_q
);
  logic [3:0] dig_q [13];
  logic [31:0] div_q;
  logic        pend_q;
  logic        deferred_q;
  logic [2:0]  bcnt_q;
  logic        hold_q;
  logic        adj_q;
  logic        cnt_busy_q;
  wire tick = (div_q == 32'(TICK_CYCLES - 1));
  wire wr_ctl = req.wr && (req.addr == RTCH_IDX_CTLD);
  wire wr_cnt = req.wr && (req.addr <= RTCH_IDX_WDAY);

  function automatic logic [3:0] wmask(input logic [3:0] a);
    unique case (a)
      RTCH_IDX_SEC10, RTCH_IDX_MIN10, RTCH_IDX_WDAY: wmask = RTCH_MASK_3BIT;
      RTCH_IDX_HR10, RTCH_IDX_DAY10:                 wmask = RTCH_MASK_2BIT;
      RTCH_IDX_MON10:                                wmask = RTCH_MASK_1BIT;
      default:                                       wmask = RTCH_MASK_4BIT;
    endcase
  endfunction

  // carry chain, used when a postponed or fresh second is applied or a half-minute round steps
  wire c0 = dig_q[0] == RTCH_MAX_DIGIT;
  wire c1 = c0 && dig_q[1] == RTCH_MAX_TENS6;
  wire c2 = c1 && dig_q[2] == RTCH_MAX_DIGIT;
  wire c3 = c2 && dig_q[3] == RTCH_MAX_TENS6;
  wire hr_wrap = c3 && dig_q[5] == 4'h2 && dig_q[4] == 4'h3;
  wire c4 = c3 && (dig_q[4] == RTCH_MAX_DIGIT || hr_wrap);
  // simplified month length: 31 days, limitation accepted for this core
  wire day_wrap = c4 && hr_wrap && dig_q[7] == 4'h3 && dig_q[6] == 4'h1;
  wire dayinc = c3 && hr_wrap;
  wire c6 = dayinc && (dig_q[6] == RTCH_MAX_DIGIT || day_wrap);
  wire mon_wrap = day_wrap && dig_q[9] == 4'h1 && dig_q[8] == 4'h2;
  wire c8 = day_wrap && (dig_q[8] == RTCH_MAX_DIGIT || mon_wrap);
  wire c10 = mon_wrap && dig_q[10] == RTCH_MAX_DIGIT;
  wire apply = (tick || pend_q) && !hold_q;
  // a half-minute round is an increment too, so it raises busy like a tick
  wire step = apply || adj_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 32'h0;
    end else begin
      div_q <= tick ? 32'h0 : div_q + 32'h1;
    end
  end

  // one deferred second only; a second tick under hold is dropped
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q     <= 1'b0;
      deferred_q <= 1'b0;
    end else if (apply) begin
      pend_q     <= 1'b0;
      deferred_q <= 1'b0;
    end else if (tick && hold_q && !deferred_q) begin
      pend_q     <= 1'b1;
      deferred_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 13; i++) dig_q[i] <= RTCH_RST_DIGIT;
    end else if (wr_cnt) begin
      dig_q[req.addr] <= req.wdata & wmask(req.addr);
    end else if (step) begin
      // bcd digit counters
      dig_q[0] <= c0 ? 4'h0 : dig_q[0] + 4'h1;
      if (c0) dig_q[1] <= c1 ? 4'h0 : dig_q[1] + 4'h1;
      if (c1) dig_q[2] <= c2 ? 4'h0 : dig_q[2] + 4'h1;
      if (c2) dig_q[3] <= c3 ? 4'h0 : dig_q[3] + 4'h1;
      if (c3) dig_q[4] <= c4 ? 4'h0 : dig_q[4] + 4'h1;
      if (c4) dig_q[5] <= hr_wrap ? 4'h0 : dig_q[5] + 4'h1;
      if (dayinc) begin
        dig_q[6] <= day_wrap ? 4'h1 : (c6 ? 4'h0 : dig_q[6] + 4'h1);
        dig_q[12] <= (dig_q[12] == RTCH_MAX_WDAY) ? 4'h0 : dig_q[12] + 4'h1;
      end
      if (c6) dig_q[7] <= day_wrap ? 4'h0 : dig_q[7] + 4'h1;
      if (day_wrap) dig_q[8] <= mon_wrap ? 4'h1 : (c8 ? 4'h0 : dig_q[8] + 4'h1);
      if (c8) dig_q[9] <= mon_wrap ? 4'h0 : dig_q[9] + 4'h1;
      if (mon_wrap) dig_q[10] <= c10 ? 4'h0 : dig_q[10] + 4'h1;
      if (c10) dig_q[11] <= (dig_q[11] == RTCH_MAX_DIGIT) ? 4'h0 : dig_q[11] + 4'h1;
    end
  end

  // busy window stretched a few cycles after each increment
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bcnt_q     <= 3'h0;
      cnt_busy_q <= 1'b0;
    end else if (step) begin
      bcnt_q     <= 3'(RTCH_BUSY_CYCLES);
      cnt_busy_q <= 1'b1;
    end else if (bcnt_q != 3'h0) begin
      bcnt_q     <= bcnt_q - 3'h1;
      cnt_busy_q <= (bcnt_q != 3'h1);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q     <= 1'b0;
      adj_q      <= 1'b0;
      irq_flag_q <= 1'b0;
      busy_q     <= 1'b1;
    end else begin
      if (wr_ctl) hold_q <= req.wdata[RTCH_BIT_HOLD];
      // half-minute round: single step, simplified to one increment
      // refused when hold is set now or in the same write, else it would slip past hold
      adj_q <= wr_ctl && req.wdata[RTCH_BIT_ADJ] && !hold_q && !req.wdata[RTCH_BIT_HOLD];
      // set wins over a simultaneous write of 0
      if (periodic_evt) irq_flag_q <= 1'b1;
      else if (wr_ctl && !req.wdata[RTCH_BIT_IRQ]) irq_flag_q <= 1'b0;
      busy_q <= !hold_q || cnt_busy_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      periodic_output_pin_q <= 1'b1;
      rdata_q               <= 4'h0;
    end else begin
      periodic_output_pin_q <= !irq_flag_q;
      if (req.rd) begin
        if (req.addr <= RTCH_IDX_WDAY) rdata_q <= dig_q[req.addr];
        else if (req.addr == RTCH_IDX_CTLD)
          rdata_q <= {1'b0, irq_flag_q, busy_q, hold_q};
        else rdata_q <= 4'h0;
      end
    end
  end

  a_busy_no_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(!hold_q) |-> busy_q) else $error("busy low while hold was 0");
  a_hold_blocks: assert property (@(posedge ref_clk) disable iff (!rst_n)
    hold_q && !wr_cnt |=> $stable(dig_q[0])) else $error("digit moved under hold");
  a_one_defer: assert property (@(posedge ref_clk) disable iff (!rst_n)
    deferred_q && hold_q && tick |=> deferred_q && pend_q) else $error("defer lost");
  a_busy_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
    apply && hold_q == 1'b0 |-> ##2 busy_q) else $error("busy missing after step");
  a_wday_range: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !wr_cnt |=> dig_q[12] <= RTCH_MAX_WDAY || $past(dig_q[12]) > RTCH_MAX_WDAY)
    else $error("weekday out of range");
  a_irq_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    periodic_evt |=> irq_flag_q) else $error("irq flag not set");
  a_irq_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_ctl && !req.wdata[RTCH_BIT_IRQ] && !periodic_evt |=> !irq_flag_q)
    else $error("irq flag not cleared");
  a_unused_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    req.rd && req.addr > RTCH_IDX_CTLD |=> rdata_q == 4'h0) else $error("unused not 0");
  a_bcd_sec: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !wr_cnt |=> dig_q[0] <= RTCH_MAX_DIGIT || $past(dig_q[0]) > RTCH_MAX_DIGIT)
    else $error("seconds digit not bcd");

  // busy must cover the whole counting window after any step
  sequence s_busy_run;
    cnt_busy_q [*4];
  endsequence
  sequence s_pend_held;
    pend_q && hold_q;
  endsequence
  sequence s_pend_free;
    pend_q && !hold_q;
  endsequence

  a_busy_window: assert property (@(posedge ref_clk) disable iff (!rst_n)
    step |=> s_busy_run) else $error("busy window too short");
  a_busy_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    bcnt_q == 3'h0 && !step |=> !cnt_busy_q) else $error("busy without step");
  a_busy_real: assert property (@(posedge ref_clk) disable iff (!rst_n)
    hold_q && !cnt_busy_q |=> !busy_q) else $error("busy high while idle under hold");
  a_busy_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    req.rd && req.addr == RTCH_IDX_CTLD |=> rdata_q[1] == $past(busy_q))
    else $error("busy bit read wrong");
  a_pend_kept: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_pend_held |=> pend_q) else $error("pending step lost under hold");
  a_pend_used: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_pend_free |=> !pend_q && cnt_busy_q) else $error("pending step not applied");
  a_drop_second: assert property (@(posedge ref_clk) disable iff (!rst_n)
    deferred_q && hold_q |=> deferred_q) else $error("deferral cleared under hold");
  a_wday_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    step && dayinc && !wr_cnt && dig_q[12] == RTCH_MAX_WDAY |=> dig_q[12] == 4'h0)
    else $error("weekday did not wrap");
  a_mask_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_cnt && req.addr == RTCH_IDX_MON10 |=> dig_q[9][3:1] == 3'h0)
    else $error("unused month bits kept");
  a_irq_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
    irq_flag_q && !(wr_ctl && !req.wdata[RTCH_BIT_IRQ]) |=> irq_flag_q)
    else $error("irq flag dropped");
  a_pin_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
    irq_flag_q |=> !periodic_output_pin_q) else $error("pin not low with flag");
endmodule
`default_nettype wire

// [tb/rtch_host.sv]
`timescale 1ns/1ps
`default_nettype none
module rtch_host
  import rtch_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic [3:0] rdata_q,
  input  wire logic       busy_q,
  output var  rtch_req_t  req
);
  initial req = '0;
  task automatic wr(input logic [3:0] a, input logic [3:0] d);
    @(posedge ref_clk) req <= '{1'b1, 1'b0, a, d};
    @(posedge ref_clk) req <= '0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [3:0] d);
    @(posedge ref_clk) req <= '{1'b0, 1'b1, a, 4'h0};
    @(posedge ref_clk) req <= '0;
    @(posedge ref_clk) #1 d = rdata_q;
  endtask
  // busy only means something once hold is set, so hold goes first
  task automatic hold_on(output bit ok);
    int n;
    wr(RTCH_IDX_CTLD, 4'h1);
    @(posedge ref_clk) #1;
    for (n = 0; n < 50 && busy_q !== 1'b0; n++) @(posedge ref_clk) #1;
    ok = (busy_q === 1'b0);
  endtask
endmodule
`default_nettype wire

// [tb/rtc_counter_hold_busy_access_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module rtc_counter_hold_busy_access_tb_top;
  import rtch_pkg::*;
  logic       ref_clk, rst_n, periodic_evt, busy_q, irq_flag_q, pin_q;
  logic [3:0] rdata_q, d, dg, m, v;
  logic [31:0] seed = 32'h0001036f;
  rtch_req_t  req;
  int         fails, check_count;
  bit         ok;
  rtch_core #(.TICK_CYCLES(20)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .req(req),
    .periodic_evt(periodic_evt), .rdata_q(rdata_q), .busy_q(busy_q),
    .irq_flag_q(irq_flag_q), .periodic_output_pin_q(pin_q));
  rtch_host host (.ref_clk(ref_clk), .rdata_q(rdata_q), .busy_q(busy_q), .req(req));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [3:0] msk(input logic [3:0] a);
    case (a)
      4'h1, 4'h3, 4'hc: return 4'h7;
      4'h5, 4'h7: return 4'h3;
      4'h9: return 4'h1;
      4'hd, 4'he, 4'hf: return 4'h0;
      default: return 4'hf;
    endcase
  endfunction
  // largest legal digit; hours tens kept below 2 so no illegal hour is formed, and day tens below 3
  function automatic logic [3:0] lim(input logic [3:0] a);
    case (a)
      4'h1, 4'h3: return 4'h5;
      4'h5, 4'h9: return 4'h1;
      4'h7: return 4'h2;
      4'hc: return 4'h6;
      default: return 4'h9;
    endcase
  endfunction
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("check_count %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (6000) @(posedge ref_clk);
    fails++;
    stop_test();
  end
  initial begin
    rst_n = 1'b0;
    periodic_evt = 1'b0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk) #1;
    chk({3'h0, busy_q}, 4'h1);
    chk({3'h0, pin_q}, 4'h1);
    // short hold windows per register keep at most one step pending
    for (int i = 0; i < 16; i++) begin
      if (i == 13) continue;
      v = 4'(xs());
      m = msk(4'(i));
      dg = v % (lim(4'(i)) + 4'h1);
      host.hold_on(ok);
      chk({3'h0, ok}, 4'h1);
      host.wr(4'(i), (dg & m) | (v & ~m));
      host.rd(4'(i), d);
      chk(d, dg & m);
      host.wr(RTCH_IDX_CTLD, 4'h0);
    end
    host.hold_on(ok);
    host.wr(RTCH_IDX_SEC10, 4'h0);
    host.wr(RTCH_IDX_MIN1, 4'h9);
    host.wr(RTCH_IDX_MIN10, 4'h5);
    host.wr(RTCH_IDX_HR1, 4'h3);
    host.wr(RTCH_IDX_HR10, 4'h2);
    host.wr(RTCH_IDX_WDAY, 4'h6);
    host.wr(RTCH_IDX_CTLD, 4'h0);
    host.hold_on(ok);
    host.wr(RTCH_IDX_SEC1, 4'h9);
    host.wr(RTCH_IDX_SEC10, 4'h5);
    repeat (22) @(posedge ref_clk);
    host.rd(RTCH_IDX_SEC1, d);
    chk(d, 4'h9);
    host.wr(RTCH_IDX_CTLD, 4'h0);
    host.hold_on(ok);
    host.rd(RTCH_IDX_HR10, d);
    chk(d, 4'h0);
    host.rd(RTCH_IDX_WDAY, d);
    chk(d, 4'h0);
    @(posedge ref_clk) periodic_evt <= 1'b1;
    @(posedge ref_clk) periodic_evt <= 1'b0;
    @(posedge ref_clk) #1;
    chk({2'h0, irq_flag_q, pin_q}, 4'h2);
    host.wr(RTCH_IDX_CTLD, 4'h4);
    host.rd(RTCH_IDX_CTLD, d);
    chk(d, 4'h6);
    host.wr(RTCH_IDX_CTLD, 4'h0);
    host.rd(RTCH_IDX_CTLD, d);
    chk(d, 4'h2);
    chk({3'h0, pin_q}, 4'h1);
    stop_test();
  end
endmodule
`default_nettype wire
